/* rtl/uamf_framer.v */
// Upstream allocation map framer: APB registers and word stream
//
// Our own choices: the register addresses and register access over APB.
`include "uamf_defines.vh"

module uamf_framer (
   input wire sys_clk_in,
   input wire reset_n_in,
   input wire psel_in,
   input wire penable_in,
   input wire pwrite_in,
   input wire [11:0] paddr_in,
   input wire [31:0] pwdata_in,
   output reg [31:0] prdata_out,
   output reg pready_out,
   output reg pslverr_out,
   output reg [7:0] version_out,
   output reg [31:0] word_out,
   output reg word_valid_out,
   output reg sop_out,
   output reg eop_out,
   input wire word_ready_in
);

   // ------------------------------------------------------------
   // Reset synchroniser
   // ------------------------------------------------------------
   reg rst_meta_r;
   reg rst_sync_r;
   always @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   wire rst_n = rst_sync_r;

   // ------------------------------------------------------------
   // State and registers
   // ------------------------------------------------------------
   localparam ST_IDLE = 3'b001;
   localparam ST_HDR = 3'b010;
   localparam ST_ELEM = 3'b100;

   reg [2:0] state_r;
   reg ofdma_r;
   reg probe_r;
   reg [8:0] count_r;
   reg [7:0] chan_r;
   reg [7:0] dcc_r;
   reg [31:0] start_r;
   reg [31:0] ack_r;
   reg [31:0] boff_r;
   reg [31:0] elem_mem [0:511];
   reg [8:0] wr_ptr_r;
   reg [8:0] rd_ptr_r;
   reg [1:0] hidx_r;
   reg err_r;
   reg done_r;
   reg [8:0] words_r;
   wire [31:0] hdr_word;

   // Count limit per version and map kind
   function [8:0] uamf_limit;
      input ofdma;
      input probe;
      begin
         if (!ofdma)
            uamf_limit = `UAMF_MAX_V1;
         else if (probe)
            uamf_limit = `UAMF_MAX_V5_PROBE;
         else
            uamf_limit = `UAMF_MAX_V5_DATA;
      end
   endfunction

   uamf_hdr_word u_hdr (
      .idx_in(hidx_r),
      .ofdma_in(ofdma_r),
      .probe_in(probe_r),
      .chan_in(chan_r),
      .dcc_in(dcc_r),
      .count_in(count_r),
      .start_in(start_r),
      .ack_in(ack_r),
      .boff_in(boff_r),
      .word_out(hdr_word)
   );

   wire busy = (state_r != ST_IDLE);
   wire acc = psel_in && penable_in && !pready_out;
   wire wr = acc && pwrite_in;
   wire [31:0] ctrl_w = pwdata_in;
   wire [8:0] req_cnt =
      ctrl_w[`UAMF_CTRL_CNT_HI:`UAMF_CTRL_CNT_LO];
   wire req_ofdma = ctrl_w[`UAMF_CTRL_OFDMA];
   wire req_probe = ctrl_w[`UAMF_CTRL_PROBE] && req_ofdma;
   wire go = wr && (paddr_in == `UAMF_ADDR_CTRL) &&
      ctrl_w[`UAMF_CTRL_GO] && !busy;
   wire go_ok = go && (req_cnt <= uamf_limit(req_ofdma, req_probe))
      && (req_cnt <= wr_ptr_r);
   wire out_fire = word_valid_out && word_ready_in;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   always @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= `UAMF_ZERO32;
         chan_r <= 8'h00;
         dcc_r <= 8'h00;
         start_r <= `UAMF_ZERO32;
         ack_r <= `UAMF_ZERO32;
         boff_r <= `UAMF_ZERO32;
         wr_ptr_r <= 9'h000;
         elem_mem[0] <= `UAMF_ZERO32;
      end else begin
         pready_out <= acc;
         pslverr_out <= 1'b0;
         prdata_out <= `UAMF_ZERO32;
         if (acc) begin
            case (paddr_in)
               `UAMF_ADDR_CTRL: begin
                  if (wr && ctrl_w[`UAMF_CTRL_GO] && busy)
                     pslverr_out <= 1'b1;
                  prdata_out <= {7'h00, count_r, 13'h0000, probe_r,
                     ofdma_r, 1'b0};
               end
               `UAMF_ADDR_CHAN: begin
                  if (wr && !busy) begin
                     chan_r <= pwdata_in[7:0];
                     dcc_r <= pwdata_in[15:8];
                  end
                  prdata_out <= {16'h0000, dcc_r, chan_r};
               end
               `UAMF_ADDR_START: begin
                  if (wr && !busy)
                     start_r <= pwdata_in;
                  prdata_out <= start_r;
               end
               `UAMF_ADDR_ACK: begin
                  if (wr && !busy)
                     ack_r <= pwdata_in;
                  prdata_out <= ack_r;
               end
               `UAMF_ADDR_BOFF: begin
                  if (wr && !busy)
                     boff_r <= pwdata_in;
                  prdata_out <= boff_r;
               end
               `UAMF_ADDR_ELEM: begin
                  // Element words queue in order; refused once full
                  if (wr && !busy) begin
                     if (wr_ptr_r == `UAMF_MAX_V5_DATA)
                        pslverr_out <= 1'b1;
                     else begin
                        elem_mem[wr_ptr_r] <= pwdata_in;
                        wr_ptr_r <= wr_ptr_r + `UAMF_ONE9;
                     end
                  end
                  prdata_out <= {23'h000000, wr_ptr_r};
               end
               `UAMF_ADDR_STAT: begin
                  prdata_out <= {15'h0000, words_r, 5'h00, done_r,
                     err_r, busy};
               end
               default: pslverr_out <= 1'b1;
            endcase
            if (wr && busy && (paddr_in != `UAMF_ADDR_STAT))
               pslverr_out <= 1'b1;
         end
         // Queue empties once the map went out whole, or when a start from idle is refused
         if (state_r == ST_ELEM && out_fire && eop_out)
            wr_ptr_r <= 9'h000;
         if (go && !go_ok)
            wr_ptr_r <= 9'h000;
      end
   end

   // ------------------------------------------------------------
   // Map sequencer
   // ------------------------------------------------------------
   always @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         ofdma_r <= 1'b0;
         probe_r <= 1'b0;
         count_r <= 9'h000;
         rd_ptr_r <= 9'h000;
         hidx_r <= 2'h0;
         err_r <= 1'b0;
         done_r <= 1'b0;
         words_r <= 9'h000;
         version_out <= `UAMF_VER_SCQAM;
         word_out <= `UAMF_ZERO32;
         word_valid_out <= 1'b0;
         sop_out <= 1'b0;
         eop_out <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (go) begin
                  err_r <= !go_ok;
                  done_r <= 1'b0;
                  if (go_ok) begin
                     ofdma_r <= req_ofdma;
                     probe_r <= req_probe;
                     count_r <= req_cnt;
                     version_out <= req_ofdma ? `UAMF_VER_OFDMA :
                        `UAMF_VER_SCQAM;
                     hidx_r <= 2'h0;
                     rd_ptr_r <= 9'h000;
                     words_r <= 9'h000;
                     state_r <= ST_HDR;
                  end
               end
            end
            ST_HDR: begin
               // Whole map streams as one message
               if (!word_valid_out || out_fire) begin
                  word_valid_out <= 1'b1;
                  word_out <= hdr_word;
                  sop_out <= (hidx_r == 2'h0);
                  eop_out <= (hidx_r == 2'h3) && (count_r == 9'h000);
                  hidx_r <= hidx_r + 2'h1;
                  if (hidx_r == 2'h3)
                     state_r <= ST_ELEM;
               end
               if (out_fire)
                  words_r <= words_r + `UAMF_ONE9;
            end
            ST_ELEM: begin
               if (out_fire) begin
                  words_r <= words_r + `UAMF_ONE9;
                  if (eop_out) begin
                     word_valid_out <= 1'b0;
                     sop_out <= 1'b0;
                     eop_out <= 1'b0;
                     done_r <= 1'b1;
                     state_r <= ST_IDLE;
                  end else begin
                     word_out <= elem_mem[rd_ptr_r];
                     sop_out <= 1'b0;
                     eop_out <= (rd_ptr_r + `UAMF_ONE9) == count_r;
                     rd_ptr_r <= rd_ptr_r + `UAMF_ONE9;
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

endmodule // uamf_framer

/* rtl/uamf_defines.vh */
// Constants for the upstream allocation map header framer
`ifndef UAMF_DEFINES_VH
`define UAMF_DEFINES_VH

// ------------------------------------------------------------
// Register map (APB byte addresses)
// ------------------------------------------------------------
`define UAMF_ADDR_CTRL 12'h000
`define UAMF_ADDR_CHAN 12'h004
`define UAMF_ADDR_START 12'h008
`define UAMF_ADDR_ACK 12'h00C
`define UAMF_ADDR_BOFF 12'h010
`define UAMF_ADDR_ELEM 12'h014
`define UAMF_ADDR_STAT 12'h018

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UAMF_CTRL_GO 0
`define UAMF_CTRL_OFDMA 1
`define UAMF_CTRL_PROBE 2
`define UAMF_CTRL_CNT_LO 16
`define UAMF_CTRL_CNT_HI 24
`define UAMF_STAT_BUSY 0
`define UAMF_STAT_ERR 1
`define UAMF_STAT_DONE 2
`define UAMF_STAT_WORDS_LO 8
`define UAMF_STAT_WORDS_HI 16

// ------------------------------------------------------------
// Header values
// ------------------------------------------------------------
`define UAMF_VER_SCQAM 8'h01
`define UAMF_VER_OFDMA 8'h05
`define UAMF_MAX_V1 9'h0F0
`define UAMF_MAX_V5_DATA 9'h1EA
`define UAMF_MAX_V5_PROBE 9'h080
`define UAMF_EXP_MASK 8'h0F
`define UAMF_HDR_WORDS 9'h004
`define UAMF_ZERO32 32'h0000_0000
`define UAMF_ONE9 9'h001

`endif

/* rtl/uamf_hdr_word.v */
// Header word builder for the allocation map
`include "uamf_defines.vh"

module uamf_hdr_word (
   input wire [1:0] idx_in,
   input wire ofdma_in,
   input wire probe_in,
   input wire [7:0] chan_in,
   input wire [7:0] dcc_in,
   input wire [8:0] count_in,
   input wire [31:0] start_in,
   input wire [31:0] ack_in,
   input wire [31:0] boff_in,
   output reg [31:0] word_out
);

   // Clip an exponent to four bits with upper bits zero
   function [7:0] uamf_exp;
      input [7:0] v;
      begin
         uamf_exp = v & `UAMF_EXP_MASK;
      end
   endfunction

   always @* begin
      case (idx_in)
         2'h0: begin
            if (ofdma_in) begin
               // 9-bit count, 6-bit pad, flag
               word_out = {chan_in, dcc_in, count_in, 3'h0, 3'h0,
                  probe_in};
            end else begin
               // 8-bit count, 8-bit pad
               word_out = {chan_in, dcc_in, count_in[7:0], 8'h00};
            end
         end
         2'h1: word_out = start_in;
         2'h2: word_out = ack_in;
         default: word_out = {uamf_exp(boff_in[31:24]),
            uamf_exp(boff_in[23:16]), uamf_exp(boff_in[15:8]),
            uamf_exp(boff_in[7:0])};
      endcase
   end

endmodule // uamf_hdr_word

/* verification/uamf_chk.sv */
// Port checker for the allocation map framer
module uamf_chk (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic [7:0] version_out,
   input wire logic [31:0] word_out,
   input wire logic word_valid_out,
   input wire logic sop_out,
   input wire logic eop_out,
   input wire logic word_ready_in
);
   logic [9:0] idx_r;
   logic [8:0] n_r;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   // ------------------------------------------------------------
   // Word index and element count of the map in flight
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         idx_r <= 10'h000;
         n_r <= 9'h000;
      end else if (word_valid_out && word_ready_in) begin
         idx_r <= sop_out ? 10'h001 : idx_r + 10'h001;
         if (sop_out) begin
            n_r <= (version_out == 8'h05) ? word_out[15:7] :
               {1'h0, word_out[15:8]};
         end
      end
   end
   a_pready_pulse: assert property (
      psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out
   ) else $error("pready not a single pulse");
   a_word_hold: assert property (
      word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_out)
   ) else $error("word changed while stalled");
   a_version_legal: assert property (
      version_out == 8'h01 || version_out == 8'h05
   ) else $error("illegal version");
   a_v1_header: assert property (
      word_valid_out && sop_out && version_out == 8'h01 |->
      word_out[7:0] == 8'h00 && word_out[15:8] <= 8'hF0
   ) else $error("bad version 1 header word");
   a_v5_header: assert property (
      word_valid_out && sop_out && version_out == 8'h05 |->
      word_out[6:1] == 6'h00 &&
      word_out[15:7] <= (word_out[0] ? 9'h080 : 9'h1EA)
   ) else $error("bad version 5 header word");
   a_boff_nibble: assert property (
      word_valid_out && !sop_out && idx_r == 10'h003 |->
      (word_out & 32'hF0F0F0F0) == 32'h00000000
   ) else $error("backoff high bits set");
   a_eop_place: assert property (
      word_valid_out && eop_out |-> !sop_out &&
      idx_r == {1'h0, n_r} + 10'h003
   ) else $error("end marker misplaced");
   a_sop_valid: assert property (
      sop_out |-> word_valid_out ##0 !eop_out
   ) else $error("start marker without word");
   cover property (word_valid_out && sop_out && version_out == 8'h05);
   cover property (word_valid_out && !word_ready_in);
   cover property (word_valid_out && eop_out && word_ready_in);
endmodule // uamf_chk

bind uamf_framer uamf_chk u_chk (.sys_clk_in(sys_clk_in),
   .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
   .pready_out(pready_out), .version_out(version_out),
   .word_out(word_out), .word_valid_out(word_valid_out),
   .sop_out(sop_out), .eop_out(eop_out), .word_ready_in(word_ready_in));

/* verification/uamf_sink.sv */
// Cable modem side model: takes map words, may stall
module uamf_sink (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic slow_in,
   input wire logic [7:0] ver_in,
   input wire logic valid_in,
   input wire logic sop_in,
   input wire logic [31:0] word_in,
   output logic ready_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:511];
   int n;
   int maps;
   logic rej;
   logic rej_r;
   // Over-limit map is not acted on
   assign rej = sop_in && ((ver_in == 8'h05) ? (word_in[15:7] >
      (word_in[0] ? 9'h080 : 9'h1EA)) : (word_in[15:8] > 8'hF0));
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ready_out <= 1'h0;
         n <= 0;
         maps <= 0;
         rej_r <= 1'h0;
      end else begin
         ready_out <= slow_in ? ~ready_out : 1'h1;
         if (valid_in && ready_out) begin
            if (sop_in) rej_r <= rej;
            if (sop_in || n < 4 || !rej_r)
               mem[sop_in ? 0 : n] <= word_in;
            n <= sop_in ? 1 : n + 1;
            if (sop_in && !rej) maps <= maps + 1;
         end
      end
   end
endmodule // uamf_sink

/* verification/upstream_alloc_map_header_framer_tb.sv */
// Testbench for the allocation map framer
`include "uamf_defines.vh"
module upstream_alloc_map_header_framer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, slow = 0;
   logic pready, perr, wv, sop, eop, wr, el;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0, prd, rd, word;
   logic [7:0] ver;
   int bad_count = 0, checks_done = 0, cyc = 0;
   uamf_framer u_uamf_framer (.sys_clk_in(clk), .reset_n_in(rst_n),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa),
      .pwdata_in(pwd), .prdata_out(prd), .pready_out(pready),
      .pslverr_out(perr), .version_out(ver), .word_out(word),
      .word_valid_out(wv), .sop_out(sop), .eop_out(eop), .word_ready_in(wr));
   uamf_sink u_uamf_sink (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
      .ver_in(ver), .valid_in(wv), .sop_in(sop), .word_in(word),
      .ready_out(wr));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         test_done;
      end
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task test_done;
      if (bad_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(string s, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      psel <= 1'h1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      // No limit of its own: only pready or the bench timeout ends this wait
      while (pready !== 1'h1) begin
         @(posedge clk);
      end
      rd = prd;
      el = perr;
      psel <= 1'h0;
      pen <= 1'h0;
      @(posedge clk);
   endtask
   function logic [31:0] ctl(logic o, logic p, int c);
      return {7'h0, c[8:0], 13'h0, p, o, 1'h1};
   endfunction
   task run(logic [31:0] c, int np);
      int k;
      for (int i = 0; i < np; i++) apb(1, `UAMF_ADDR_ELEM, 32'hABCD0000 + i);
      apb(1, `UAMF_ADDR_CTRL, c);
      k = 0;
      do begin
         apb(0, `UAMF_ADDR_STAT, 32'h0);
         k++;
      end while (rd[0] !== 1'h0 && k < 400);
   endtask
   task map_check(logic o, logic p, int n);
      chk("ver", o ? 32'h5 : 32'h1, {24'h0, ver});
      chk("hdr", o ? {16'h5A3C, n[8:0], 6'h0, p} :
         {16'h5A3C, n[7:0], 8'h00}, u_uamf_sink.mem[0]);
      chk("start", 32'h00012345, u_uamf_sink.mem[1]);
      chk("ack", 32'h00012300, u_uamf_sink.mem[2]);
      chk("boff", 32'h0F0A0B0C, u_uamf_sink.mem[3]);
      for (int i = 0; i < n; i++)
         chk("elem", 32'hABCD0000 + i, u_uamf_sink.mem[4 + i]);
      chk("words", n + 4, u_uamf_sink.n);
      chk("stat", ((n + 4) << 8) | 4, rd & 32'h1FF07);
   endtask
   task refused(logic [31:0] c, int np);
      int m;
      m = u_uamf_sink.maps;
      run(c, np);
      chk("err", 32'h1, {31'h0, rd[1]});
      chk("maps", m, u_uamf_sink.maps);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_v1_map;
      slow <= 1'h1;
      apb(1, `UAMF_ADDR_CHAN, 32'h00003C5A);
      apb(1, `UAMF_ADDR_START, 32'h00012345);
      apb(1, `UAMF_ADDR_ACK, 32'h00012300);
      apb(1, `UAMF_ADDR_BOFF, 32'hFF1A2B3C);
      run(ctl(0, 0, 3), 3);
      map_check(0, 0, 3);
   endtask
   task t_v5_maps;
      for (int p = 0; p < 2; p++) begin
         slow <= p[0];
         run(ctl(1, p[0], 2), 2);
         map_check(1, p[0], 2);
      end
   endtask
   task t_limits;
      slow <= 1'h0;
      refused(ctl(0, 0, 241), 241);
      run(ctl(0, 0, 240), 240);
      map_check(0, 0, 240);
      refused(ctl(1, 1, 129), 129);
      run(ctl(1, 1, 128), 128);
      map_check(1, 1, 128);
      refused(ctl(1, 0, 491), 491);
      run(ctl(1, 0, 490), 490);
      map_check(1, 0, 490);
   endtask
   task t_bad_addr;
      apb(0, 12'h01C, 32'h0);
      chk("slverr", 32'h1, {31'h0, el});
      apb(1, 12'h020, 32'h1);
      chk("slverr", 32'h1, {31'h0, el});
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      t_v1_map;
      t_v5_maps;
      t_limits;
      t_bad_addr;
      test_done;
   end
endmodule // upstream_alloc_map_header_framer_tb
